// ==== pulse_train_map.svh ====
/*
  Holds the register map, field positions, reset values and timing figures
  of the triggered pulse train generator.
  Assumes a 100 MHz clock and a 32-bit APB bus with 12-bit byte addresses.
*/
`ifndef PULSE_TRAIN_MAP_SVH
`define PULSE_TRAIN_MAP_SVH

// clock
`define CLK_PERIOD_NS 10

// register byte offsets
`define OFS_CTRL      12'h000
`define OFS_COUNT     12'h004
`define OFS_EDGE      12'h008
`define OFS_DELAY     12'h00C
`define OFS_PERIOD_LO 12'h010
`define OFS_PERIOD_HI 12'h014
`define OFS_MANUAL    12'h018
`define OFS_STATUS    12'h01C
`define OFS_TABLE     12'h040
`define TABLE_STRIDE  12'h008
`define TABLE_LO_BIT  2

// control fields
`define CTRL_EN_BIT   0
`define CTRL_SRC_LSB  1
`define CTRL_POL_BIT  3
`define CTRL_IDLE_LSB 4

// status fields
`define STAT_BUSY_BIT  0
`define STAT_STATE_LSB 1
`define STAT_IDX_LSB   4

// pulse count limits
`define COUNT_MIN 5'd2
`define COUNT_MAX 30

// times, in their own units
`define WIDTH_MIN_NS 20
`define WIDTH_MAX_NS 150000
`define EDGE_MIN_NS  2
`define EDGE_MAX_NS  1000
`define TIMER_MIN_NS 5000
`define TIMER_MAX_S  8000
`define DELAY_MAX_S  1

// derived cycle counts: least times round up, longest round down
`define WIDTH_MIN_CYC ((`WIDTH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WIDTH_MAX_CYC (`WIDTH_MAX_NS / `CLK_PERIOD_NS)
`define TIMER_MIN_CYC ((`TIMER_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_MAX_CYC (64'd`TIMER_MAX_S * 64'd1000000000 / `CLK_PERIOD_NS)
`define DELAY_MAX_CYC (`DELAY_MAX_S * 1000000000 / `CLK_PERIOD_NS)

// reset values
`define RST_CTRL   32'h0000_0000
`define RST_DELAY  27'h000_0000

`endif

// ==== pulse_train_pkg.sv ====
/*
  Holds the types of the triggered pulse train generator: modes, states
  and the structs carried on the bus and toward the output stage.
  Assumes the map header supplies every numeric constant.
*/
`default_nettype none

package pulse_train_pkg;

  typedef enum logic [1:0] {src_off, src_ext, src_manual, src_timer}
    trig_src_e;

  typedef enum logic [1:0] {
    idle_first_sample_level, idle_top, idle_center, idle_bottom
  } idle_sel_e;

  typedef enum logic [1:0] {lvl_bottom, lvl_center, lvl_top} level_e;

  typedef enum logic [2:0] {st_idle, st_delay, st_high, st_low}
    play_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic        out_on;
    level_e      level;
    logic        playing;
    logic [9:0]  edge_ns;
  } stage_s;

endpackage

`default_nettype wire

// ==== pulse_train_gen.sv ====
/*
  Triggered pulse train generator: APB register file, trigger selection,
  trigger delay, internal timer and the pulse playout sequencer.
  Assumes a 100 MHz ref_clk, synchronous active-high rst, an APB master
  on the same clock and an asynchronous auxiliary trigger pin.
*/
// The APB register port and the register offsets were left to the implementer.
// Function
// (RULE_01) pulse count per train is 2 to 30
// (RULE_02) each pulse has own high and low width, 20 ns to 150 us
// (RULE_03) one edge time 2 ns to 1 us, not above smallest width
// (RULE_04) trigger source is off, external, manual or timer
// (RULE_05) source off: train replays continuously while output enabled
// (RULE_06) external: one train per aux edge of chosen polarity
// (RULE_07) manual: one train per manual trigger request
// (RULE_08) timer: periodic events 5 us to 8 ks, one train each
// (RULE_09) timer period below delay plus all widths is refused
// (RULE_10) events arriving while a train is pending or playing are ignored
// (RULE_11) output stays on at idle level when no pulse plays
// (RULE_12) idle level is first sample, top, centre or bottom
// (RULE_13) programmable trigger delay up to 1 s before first pulse
// (RULE_14) with source off the trigger delay is not applied
// (RULE_15) pulses play in order, high then low, then idle
`timescale 1ns/1ps
`default_nettype none
`include "pulse_train_map.svh"

module pulse_train_gen
#(
  parameter logic [13:0] WIDTH_MAX  = 14'(`WIDTH_MAX_CYC),
  parameter logic [26:0] DELAY_MAX  = 27'(`DELAY_MAX_CYC),
  parameter logic [39:0] PERIOD_MAX = 40'(`TIMER_MAX_CYC),
  parameter logic [39:0] PERIOD_MIN = 40'(`TIMER_MIN_CYC)
)
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire pulse_train_pkg::apb_req_s apb_req,
  output var  pulse_train_pkg::apb_rsp_s apb_rsp,
  input  wire logic                   aux_trig_in,
  output var  pulse_train_pkg::stage_s stage
);
  import pulse_train_pkg::*;

  localparam int N = `COUNT_MAX;

  // parameters the counters cannot hold
  if (WIDTH_MAX < 14'(`WIDTH_MIN_CYC) || PERIOD_MIN == 40'h0000_0000
      || PERIOD_MAX < PERIOD_MIN)
  begin : g_bad_param
    $error("pulse_train_gen: bad timing parameter");
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration state
  logic        en_reg, en_next;
  trig_src_e   src_reg, src_next;
  logic        pol_reg, pol_next;
  idle_sel_e   idle_reg, idle_next;
  logic [4:0]  count_reg, count_next;
  logic [9:0]  edge_reg, edge_next;
  logic [26:0] delay_reg, delay_next;
  logic [39:0] period_reg, period_next;
  logic [7:0]  period_hi_reg, period_hi_next;
  logic        manual_reg, manual_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [13:0] hi_w [N];
  logic [13:0] lo_w [N];

  // playout state
  play_state_e state_reg, state_next;
  logic [4:0]  idx_reg, idx_next;
  logic [26:0] cnt_reg, cnt_next;
  logic [39:0] tmr_reg, tmr_next;
  level_e      level_reg, level_next;
  logic        sync1_reg, sync2_reg, sync3_reg;

  // decode, sums and checks
  logic        acc, wr, setup, mapped, tbl_hit, tbl_lo, refuse;
  logic [11:0] tbl_ofs;
  logic [4:0]  tbl_idx;
  logic [19:0] width_sum;
  logic [13:0] width_min;
  logic [28:0] busy_cyc;
  logic [13:0] wval;
  logic [39:0] new_period;
  logic        trig, tmr_evt, ext_edge;

  //////////////////////////////////////////////////////////////////////////
  // sums and minimum of the widths in use, for the period and edge checks
  always_comb
  begin
    width_sum = 20'h0_0000;
    width_min = WIDTH_MAX;
    for (int i = 0; i < N; i++)
    begin
      if (5'(i) < count_reg)
      begin
        width_sum = width_sum + 20'(hi_w[i]) + 20'(lo_w[i]);
        if (hi_w[i] < width_min) width_min = hi_w[i];
        if (lo_w[i] < width_min) width_min = lo_w[i];
      end
    end
    busy_cyc = 29'(delay_reg) + 29'(width_sum);
  end

  // address decode; table entries are a high/low word pair
  always_comb
  begin
    acc      = apb_req.psel & apb_req.penable;
    wr       = acc & apb_req.pwrite;
    setup    = apb_req.psel & ~apb_req.penable;
    tbl_ofs  = apb_req.paddr - `OFS_TABLE;
    tbl_idx  = 5'(tbl_ofs / `TABLE_STRIDE);
    tbl_lo   = tbl_ofs[`TABLE_LO_BIT];
    tbl_hit  = (apb_req.paddr >= `OFS_TABLE)
               && (tbl_ofs < 12'(N) * `TABLE_STRIDE)
               && (apb_req.paddr[1:0] == 2'b00);
    mapped   = tbl_hit || (apb_req.paddr <= `OFS_STATUS
               && apb_req.paddr[1:0] == 2'b00);
    wval     = apb_req.pwdata[13:0];
    new_period = {period_hi_reg, apb_req.pwdata};
  end

  //////////////////////////////////////////////////////////////////////////
  // register writes; out-of-range values are refused with pslverr
  always_comb
  begin
    en_next        = en_reg;
    src_next       = src_reg;
    pol_next       = pol_reg;
    idle_next      = idle_reg;
    count_next     = count_reg;
    edge_next      = edge_reg;
    delay_next     = delay_reg;
    period_next    = period_reg;
    period_hi_next = period_hi_reg;
    manual_next    = 1'b0;
    refuse         = 1'b0;
    if (wr && !tbl_hit)
    begin
      case (apb_req.paddr)
        `OFS_CTRL:
        begin
          en_next   = apb_req.pwdata[`CTRL_EN_BIT];
          src_next  = trig_src_e'(apb_req.pwdata[`CTRL_SRC_LSB +: 2]); // see RULE_04
          pol_next  = apb_req.pwdata[`CTRL_POL_BIT];
          idle_next = idle_sel_e'(apb_req.pwdata[`CTRL_IDLE_LSB +: 2]); // see RULE_12
        end
        `OFS_COUNT:
          if (apb_req.pwdata < 32'(`COUNT_MIN) || apb_req.pwdata > 32'(N))
            refuse = 1'b1; // see RULE_01
          else
            count_next = apb_req.pwdata[4:0];
        `OFS_EDGE:
          if (apb_req.pwdata < 32'(`EDGE_MIN_NS)
              || apb_req.pwdata > 32'(`EDGE_MAX_NS)
              || apb_req.pwdata > 32'(width_min) * `CLK_PERIOD_NS)
            refuse = 1'b1; // see RULE_03
          else
            edge_next = apb_req.pwdata[9:0];
        `OFS_DELAY:
          if (apb_req.pwdata > 32'(DELAY_MAX))
            refuse = 1'b1; // see RULE_13
          else
            delay_next = apb_req.pwdata[26:0];
        `OFS_PERIOD_HI:
          period_hi_next = apb_req.pwdata[7:0]; // staged until low write
        `OFS_PERIOD_LO:
          if (new_period < PERIOD_MIN || new_period > PERIOD_MAX)
            refuse = 1'b1; // see RULE_08
          else if (new_period < 40'(busy_cyc))
            refuse = 1'b1; // see RULE_09
          else
            period_next = new_period;
        `OFS_MANUAL:
          manual_next = apb_req.pwdata[0]; // see RULE_07
        default:
          refuse = !mapped;
      endcase
    end
    else if (wr)
    begin
      // widths outside range or narrower than the edge are refused
      if (wval < 14'(`WIDTH_MIN_CYC) || wval > WIDTH_MAX
          || apb_req.pwdata[31:14] != 18'h0_0000
          || 32'(wval) * `CLK_PERIOD_NS < 32'(edge_reg))
        refuse = 1'b1; // see RULE_02
    end
    else if (acc && !mapped)
      refuse = 1'b1;
  end

  // read data captured in setup so it comes from a flip-flop
  always_comb
  begin
    rdata_next = rdata_reg;
    if (setup)
    begin
      rdata_next = 32'h0000_0000;
      if (tbl_hit)
        rdata_next = 32'(tbl_lo ? lo_w[tbl_idx] : hi_w[tbl_idx]);
      else
        case (apb_req.paddr)
          `OFS_CTRL:      rdata_next = 32'({idle_reg, pol_reg, src_reg,
                                            en_reg});
          `OFS_COUNT:     rdata_next = 32'(count_reg);
          `OFS_EDGE:      rdata_next = 32'(edge_reg);
          `OFS_DELAY:     rdata_next = 32'(delay_reg);
          `OFS_PERIOD_LO: rdata_next = period_reg[31:0];
          `OFS_PERIOD_HI: rdata_next = 32'(period_reg[39:32]);
          `OFS_STATUS:
          begin
            rdata_next[`STAT_BUSY_BIT]       = state_reg != st_idle;
            rdata_next[`STAT_STATE_LSB +: 3] = state_reg;
            rdata_next[`STAT_IDX_LSB +: 5]   = idx_reg;
          end
          default:        rdata_next = 32'h0000_0000;
        endcase
    end
  end

  always_comb
  begin
    apb_rsp.prdata  = rdata_reg;
    apb_rsp.pready  = 1'b1; // zero wait states
    apb_rsp.pslverr = acc & refuse;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      en_reg        <= 1'b0;
      src_reg       <= src_off;
      pol_reg       <= 1'b0;
      idle_reg      <= idle_first_sample_level;
      count_reg     <= `COUNT_MIN;
      edge_reg      <= 10'(`EDGE_MIN_NS);
      delay_reg     <= `RST_DELAY;
      period_reg    <= PERIOD_MAX;
      period_hi_reg <= 8'h00;
      manual_reg    <= 1'b0;
      rdata_reg     <= 32'h0000_0000;
    end
    else
    begin
      en_reg        <= en_next;
      src_reg       <= src_next;
      pol_reg       <= pol_next;
      idle_reg      <= idle_next;
      count_reg     <= count_next;
      edge_reg      <= edge_next;
      delay_reg     <= delay_next;
      period_reg    <= period_next;
      period_hi_reg <= period_hi_next;
      manual_reg    <= manual_next;
      rdata_reg     <= rdata_next;
    end
  end

  // width table, one high and one low word per pulse
  for (genvar g = 0; g < N; g++)
  begin : g_tbl
    always_ff @(posedge ref_clk)
    begin
      if (rst)
      begin
        hi_w[g] <= 14'(`WIDTH_MIN_CYC);
        lo_w[g] <= 14'(`WIDTH_MIN_CYC);
      end
      else if (wr && tbl_hit && !refuse && tbl_idx == 5'(g))
      begin
        if (tbl_lo) lo_w[g] <= wval; // see RULE_02
        else        hi_w[g] <= wval;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // aux pin synchroniser; the edge is taken between second and third stage
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= aux_trig_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // trigger selection and internal timer
  always_comb
  begin
    ext_edge = pol_reg ? (~sync2_reg & sync3_reg)  // trailing
                       : (sync2_reg & ~sync3_reg); // leading, see RULE_06
    tmr_evt  = (src_reg == src_timer) && en_reg
               && (tmr_reg >= period_reg - 40'h00_0000_0001); // see RULE_08
    tmr_next = (en_reg && src_reg == src_timer && !tmr_evt)
               ? tmr_reg + 40'h00_0000_0001 : 40'h00_0000_0000;
    case (src_reg)
      src_ext:    trig = ext_edge;
      src_manual: trig = manual_reg; // see RULE_07
      src_timer:  trig = tmr_evt;
      default:    trig = 1'b0;
    endcase
  end

  // playout sequencer
  always_comb
  begin
    state_next = state_reg;
    idx_next   = idx_reg;
    cnt_next   = cnt_reg;
    if (!en_reg)
      state_next = st_idle;
    else
      case (state_reg)
        st_idle:
          if (src_reg == src_off)
          begin
            state_next = st_high; // no delay here, see RULE_05 RULE_14
            idx_next   = 5'd0;
            cnt_next   = 27'(hi_w[0]) - 27'd1;
          end
          else if (trig && delay_reg == 27'd0)
          begin
            state_next = st_high;
            idx_next   = 5'd0;
            cnt_next   = 27'(hi_w[0]) - 27'd1;
          end
          else if (trig)
          begin
            state_next = st_delay; // see RULE_13
            cnt_next   = delay_reg - 27'd1;
          end
        st_delay:
          // triggers here and in playout are dropped, see RULE_10
          if (cnt_reg == 27'd0)
          begin
            state_next = st_high;
            idx_next   = 5'd0;
            cnt_next   = 27'(hi_w[0]) - 27'd1;
          end
          else
            cnt_next = cnt_reg - 27'd1;
        st_high:
          if (cnt_reg == 27'd0)
          begin
            state_next = st_low; // see RULE_15
            cnt_next   = 27'(lo_w[idx_reg]) - 27'd1;
          end
          else
            cnt_next = cnt_reg - 27'd1;
        st_low:
          if (cnt_reg != 27'd0)
            cnt_next = cnt_reg - 27'd1;
          else if (idx_reg == count_reg - 5'd1)
            state_next = st_idle; // see RULE_15
          else
          begin
            state_next = st_high;
            idx_next   = idx_reg + 5'd1;
            cnt_next   = 27'(hi_w[idx_reg + 5'd1]) - 27'd1;
          end
        default:
          state_next = st_idle;
      endcase
  end

  // level toward the output stage; first sample of a train is its top
  always_comb
  begin
    case (state_next)
      st_high: level_next = lvl_top;
      st_low:  level_next = lvl_bottom;
      default:
        case (idle_reg) // see RULE_12
          idle_top:    level_next = lvl_top;
          idle_center: level_next = lvl_center;
          idle_bottom: level_next = lvl_bottom;
          default:     level_next = lvl_top;
        endcase
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= st_idle;
      idx_reg   <= 5'd0;
      cnt_reg   <= 27'd0;
      tmr_reg   <= 40'h00_0000_0000;
      level_reg <= lvl_top;
    end
    else
    begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      cnt_reg   <= cnt_next;
      tmr_reg   <= tmr_next;
      level_reg <= level_next;
    end
  end

  // stage stays driven whenever enabled, idle or not
  always_comb
  begin
    stage.out_on  = en_reg; // see RULE_11
    stage.level   = level_reg;
    stage.playing = (state_reg == st_high) || (state_reg == st_low);
    stage.edge_ns = edge_reg; // see RULE_03
  end

endmodule

`default_nettype wire

// ==== pulse_train_gen_monitor.sv ====
/*
  Port checker for the pulse train generator, bound to its top module.
  Assumes one clock domain and the register offsets of the map header.
*/
`timescale 1ns/1ps
`default_nettype none

module pulse_train_gen_monitor
  import pulse_train_pkg::*;
(
  input wire logic      ref_clk,
  input wire logic      rst,
  input wire apb_req_s  apb_req,
  input wire apb_rsp_s  apb_rsp,
  input wire logic      aux_trig_in,
  input wire stage_s    stage
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // write access in its access phase
  logic acc;
  assign acc = apb_req.psel && apb_req.penable && apb_req.pwrite;

  //////////////////////////////////////////////////////////////////////////////
  chk_count_refused: assert property (
    acc && apb_req.paddr == 12'h004 && (apb_req.pwdata < 32'h0000_0002
    || apb_req.pwdata > 32'h0000_001e) |-> apb_rsp.pslverr)
    else $error("pulse count out of range was accepted");
  chk_width_refused: assert property (
    acc && apb_req.paddr >= 12'h040 && apb_req.paddr < 12'h130
    && apb_req.pwdata < 32'h0000_0002 |-> apb_rsp.pslverr)
    else $error("too short width was accepted");
  chk_edge_refused: assert property (
    acc && apb_req.paddr == 12'h008 && (apb_req.pwdata < 32'h0000_0002
    || apb_req.pwdata > 32'h0000_03e8) |-> apb_rsp.pslverr)
    else $error("edge time out of range was accepted");
  chk_edge_held: assert property (
    stage.edge_ns >= 10'd2 && stage.edge_ns <= 10'd1000)
    else $error("edge time output out of range");
  chk_play_levels: assert property (
    stage.playing |-> stage.level == lvl_top || stage.level == lvl_bottom)
    else $error("level during playout not top or bottom");
  chk_first_high: assert property (
    $rose(stage.playing) |-> (stage.level == lvl_top) [*2])
    else $error("train did not open with a high phase");
  // aborts by disabling the output are excused
  chk_phase_min: assert property (
    stage.playing && $past(stage.playing) && $changed(stage.level)
    |=> $stable(stage.level) || !stage.out_on)
    else $error("phase shorter than two cycles");
  chk_train_min: assert property (
    $rose(stage.playing) |-> (stage.playing || !stage.out_on) [*8])
    else $error("train shorter than two pulses");
  chk_off_idle: assert property (
    !stage.out_on |=> !stage.playing)
    else $error("playout continued with output disabled");

  // main scenarios reached
  cover property ($rose(stage.playing));
  cover property (apb_rsp.pslverr);
  cover property ($changed(aux_trig_in));
endmodule

bind pulse_train_gen pulse_train_gen_monitor u_mon (
  .ref_clk    (ref_clk),
  .rst        (rst),
  .apb_req    (apb_req),
  .apb_rsp    (apb_rsp),
  .aux_trig_in(aux_trig_in),
  .stage      (stage)
);

`default_nettype wire

// ==== trig_stage_model.sv ====
/*
  Far-side model: external trigger source and an output stage that counts
  pulses, playout cycles and high cycles.
  Assumes the stage struct of the package and the bench clock.
*/
`timescale 1ns/1ps
`default_nettype none

module trig_stage_model
  import pulse_train_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire stage_s stage,
  output var  logic   aux_trig_in
);
  int   pulses = 0;
  int   play_cyc = 0;
  int   top_cyc = 0;
  logic was_top = 1'b0;
  logic is_top;

  initial aux_trig_in = 1'b0;

  // output stage: a pulse starts where the level goes high in playout
  always @(posedge ref_clk)
  begin
    is_top = stage.playing === 1'b1 && stage.level === lvl_top;
    if (stage.playing === 1'b1)
      play_cyc++;
    if (is_top)
      top_cyc++;
    if (is_top && !was_top)
      pulses++;
    was_top = is_top;
  end

  task clear;
    pulses = 0;
    play_cyc = 0;
    top_cyc = 0;
  endtask

  // one edge, then quiet long enough for a whole delayed train
  task fire;
    @(posedge ref_clk);
    aux_trig_in <= ~aux_trig_in;
    repeat (40) @(posedge ref_clk);
  endtask
endmodule

`default_nettype wire

// ==== triggered_pulse_train_generator_tb.sv ====
/*
  Self-checking bench of the pulse train generator over APB.
  Assumes a 100 MHz clock, shortened delay and period limits.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pulse_train_map.svh"

module triggered_pulse_train_generator_tb;
  import pulse_train_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  apb_req_s    apb_req = '0;
  apb_rsp_s    apb_rsp;
  wire logic   aux_trig_in;
  stage_s      stage;
  int          failures = 0;
  int          samples_checked = 0;
  int          n;
  logic        err;
  logic [31:0] rd;
  level_e      idle_exp [4] = '{lvl_top, lvl_top, lvl_center, lvl_bottom};

  always #5 ref_clk = ~ref_clk;

  pulse_train_gen #(.DELAY_MAX(27'd1000), .PERIOD_MIN(40'd20)) dut (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .apb_req    (apb_req),
    .apb_rsp    (apb_rsp),
    .aux_trig_in(aux_trig_in),
    .stage      (stage)
  );

  trig_stage_model part (
    .ref_clk    (ref_clk),
    .stage      (stage),
    .aux_trig_in(aux_trig_in)
  );

  //////////////////////////////////////////////////////////////////////////////
  task chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // setup, then access held until pready is seen at an edge;
  // only the watchdog ends a wait that never gets an answer
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
    end
    while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk(err, e);
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, x);
  endtask

  // counts edges until playout is seen, bounded
  task wait_play;
    n = 0;
    while (stage.playing !== 1'b1 && n < 500)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rdc(`OFS_COUNT, 2);
    rdc(`OFS_EDGE, 2);
    rdc(`OFS_DELAY, 0);
    rdc(`OFS_CTRL, 0);
    wr(`OFS_COUNT, 1, 1);
    wr(`OFS_COUNT, 31, 1);
    wr(`OFS_COUNT, 30, 0);
    rdc(`OFS_COUNT, 30);
    wr(`OFS_COUNT, 2, 0);
    wr(`OFS_EDGE, 1001, 1);
    wr(`OFS_EDGE, 21, 1);
    wr(`OFS_EDGE, 20, 0);
    wr(12'h040, 1, 1);
    wr(12'h040, 15001, 1);
    wr(`OFS_DELAY, 1001, 1);
    wr(12'h200, 0, 1);
    wr(12'h040, 3, 0);
    wr(12'h044, 2, 0);
    wr(12'h048, 2, 0);
    wr(12'h04c, 4, 0);
  endtask

  task t_idle;
    for (int i = 0; i < 4; i++)
    begin
      wr(`OFS_CTRL, 32'h0000_0005 | (i << 4), 0);
      // level register follows the new idle select one edge later
      repeat (2) @(posedge ref_clk);
      chk(stage.out_on, 1);
      chk(stage.level, idle_exp[i]);
    end
    chk(stage.edge_ns, 20);
  endtask

  // second request lands while the first train plays
  task t_manual;
    part.clear();
    wr(`OFS_MANUAL, 1, 0);
    wr(`OFS_MANUAL, 1, 0);
    repeat (40) @(posedge ref_clk);
    chk(part.pulses, 2);
    chk(part.play_cyc, 11);
    chk(part.top_cyc, 5);
    chk(stage.level, lvl_bottom);
  endtask

  task t_delay;
    wr(`OFS_DELAY, 10, 0);
    wr(`OFS_MANUAL, 1, 0);
    wait_play();
    // delay of 10, one cycle to take the trigger, one to see playout
    chk(n, 12);
    repeat (40) @(posedge ref_clk);
  endtask

  // both polarities, each met by a matching and a wrong edge
  task t_ext;
    wr(`OFS_CTRL, 32'h0000_0003, 0);
    part.clear();
    part.fire();
    chk(part.pulses, 2);
    part.fire();
    chk(part.pulses, 2);
    wr(`OFS_CTRL, 32'h0000_000b, 0);
    part.fire();
    chk(part.pulses, 2);
    part.fire();
    chk(part.pulses, 4);
  endtask

  task t_timer;
    wr(`OFS_PERIOD_HI, 0, 0);
    wr(`OFS_PERIOD_LO, 20, 1);
    wr(`OFS_PERIOD_LO, 5, 1);
    wr(`OFS_PERIOD_LO, 60, 0);
    wr(`OFS_CTRL, 32'h0000_0007, 0);
    part.clear();
    repeat (300) @(posedge ref_clk);
    wr(`OFS_CTRL, 0, 0);
    chk(part.pulses >= 8 && part.pulses <= 10, 1);
  endtask

  // delay of 10 stays set: free run must ignore it
  task t_off;
    wr(`OFS_CTRL, 32'h0000_0001, 0);
    wait_play();
    chk(n, 2);
    n = 0;
    while (stage.playing !== 1'b0 && n < 100)
    begin
      @(posedge ref_clk);
      n++;
    end
    wait_play();
    chk(n, 1);
    wr(`OFS_CTRL, 0, 0);
    repeat (2) @(posedge ref_clk);
    chk(stage.out_on, 0);
    chk(stage.playing, 0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    failures++;
    print_verdict();
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_idle();
    t_manual();
    t_delay();
    t_ext();
    t_timer();
    t_off();
    print_verdict();
  end
endmodule

`default_nettype wire
